// ---- gport_grant_pkg.sv ----
// shared constants and state codes for the graphics port grant pipeliner
// assumes one 10 MHz system clock; all timings below are in those clocks
`default_nettype none
package gport_grant_pkg;
    // grant status code values driven with the grant
    localparam logic [2:0] ST_REQUEST    = 3'h7;  // grant for a request slot
    localparam logic [2:0] ST_READ_DATA  = 3'h0;  // read data return, 00x
    localparam logic [2:0] ST_WRITE_DATA = 3'h2;  // master supplies write data, 01x
    localparam logic [2:0] ST_RESET      = 3'h7;  // code shown while no grant
    // idle gap before a fresh request grant
    localparam int unsigned GAP_TIME_CLKS = 2;     // clocks, as given
    localparam logic [1:0]  GAP_CYCLES    = 2'(GAP_TIME_CLKS);
    // back-to-back transactions allowed under one held grant
    localparam logic [1:0]  B2B_MAX       = 2'h2;
    // reset values
    localparam logic        GNT_N_RESET   = 1'b1;
    localparam logic [1:0]  CNT_RESET     = 2'h0;
    // arbiter states, one-hot
    typedef enum logic [5:0] {
        S_IDLE     = 6'b00_0001,  // waiting for the two-clock idle gap
        S_GNT_REQ  = 6'b00_0010,  // request grant out, waiting for a start
        S_PIPE_ACT = 6'b00_0100,  // pipelined request being enqueued
        S_WAIT_REQ = 6'b00_1000,  // pipelined burst done, waiting for req
        S_PCI_ACT  = 6'b01_0000,  // pci transaction in progress
        S_CORE     = 6'b10_0000   // internal grant to the core logic
    } arb_state_t;
endpackage
`default_nettype wire

// ---- gport_pin_sampler.sv ----
// pin sampler: two-flop synchroniser, optionally one more register stage
// assumes active-low pins that idle high; reset drives the idle level
`default_nettype none
module gport_pin_sampler #(
    parameter int unsigned WIDTH      = 3,
    parameter bit          REGISTERED = 1'b0  // extra sampling stage
) (
    // clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    input  wire logic             i_clk_en,
    // pins in, samples out
    input  wire logic [WIDTH-1:0] i_pins_n,
    output var  logic [WIDTH-1:0] o_sampled_n
);
    logic [WIDTH-1:0] meta_q;   // first stage, read by second stage only
    logic [WIDTH-1:0] sync_q;   // second stage, safe to use
    logic [WIDTH-1:0] late_q;   // optional latched copy

    // synchroniser chain; every stage frozen by the clock enable
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_q <= '1;
            sync_q <= '1;
            late_q <= '1;
        end else if (i_clk_en) begin
            meta_q <= i_pins_n;
            sync_q <= meta_q;
            late_q <= sync_q;
        end
    end

    // registered build trades one clock of grant latency for timing slack
    assign o_sampled_n = REGISTERED ? late_q : sync_q;
endmodule
`default_nettype wire

// ---- gport_grant_arbiter.sv ----
// grant pipelining arbiter for the graphics port, core logic side
// assumes the master keeps its own turn-around and dead-clock duties
// What this block does
// - no request grant while pipelined request active
// - pipe end with req asserted grants next
// - req reassertion gates grant after multi-request burst
// - grant next slot once frame sampled asserted
// - grant may be withdrawn at any clock
// - hold grant for back-to-back master transactions
// - drop grant early on retry, before third
// - pci read then pipe: its two turn-arounds are left to the master
// - hold grant across pci into pipelined request
// - data grant as soon as request started
// - request code may linger after start
// - fresh grant after two quiet ungranted clocks
// - read data return uses status 00x
// - write data request uses status 01x
`default_nettype none
module gport_grant_arbiter #(
    parameter bit REGISTERED_INPUTS = 1'b0  // adds one clock to grant timing
) (
    // clock, reset, enable
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic       i_clk_en,
    // master pins, active low, asynchronous to this clock
    input  wire logic       i_req_n,
    input  wire logic       i_frame_n,
    input  wire logic       i_pipe_n,
    // core logic side, same clock
    input  wire logic       i_core_req,     // core wants to start a pci cycle
    input  wire logic       i_rd_pending,   // read data ready to return
    input  wire logic       i_wr_pending,   // write data wanted from master
    input  wire logic       i_stop_early,   // target will retry this cycle
    // grant pins to the master
    output var  logic       o_gnt_n,
    output var  logic [2:0] o_grant_status_code,
    // core logic side
    output var  logic       o_core_gnt,     // internal grant to core
    output var  logic       o_data_grant    // one-clock: data slot queued
);
    // sampled pins, active high after inversion
    logic [2:0] pins_n;           // {req, frame, pipe} sampled, active low
    logic       s_req;
    logic       s_frame;
    logic       s_pipe;

    // arbiter state
    gport_grant_pkg::arb_state_t state_q, state_d;
    logic       gnt_n_q, gnt_n_d;       // grant pin
    logic [2:0] st_q, st_d;             // status code pin
    logic       core_gnt_q, core_gnt_d; // internal grant
    logic       dgnt_q, dgnt_d;         // data grant pulse
    logic [1:0] gap_q, gap_d;           // quiet ungranted clocks
    logic [1:0] b2b_q, b2b_d;           // transactions under a held grant
    logic       gap_ok;                 // idle gap reached
    logic       req_held;               // request-code grant is out

    gport_pin_sampler #(
        .WIDTH      (3),
        .REGISTERED (REGISTERED_INPUTS)
    ) u_sampler (
        .i_clk_sys   (i_clk_sys),
        .i_sys_rst   (i_sys_rst),
        .i_clk_en    (i_clk_en),
        .i_pins_n    ({i_req_n, i_frame_n, i_pipe_n}),
        .o_sampled_n (pins_n)
    );

    assign s_req    = ~pins_n[2];
    assign s_frame  = ~pins_n[1];
    assign s_pipe   = ~pins_n[0];
    assign gap_ok   = (gap_q >= gport_grant_pkg::GAP_CYCLES);
    assign req_held = ~gnt_n_q && (st_q == gport_grant_pkg::ST_REQUEST);

    // next-state logic for the grant sequencer
    always_comb begin
        state_d    = state_q;
        gnt_n_d    = 1'b1;                          // grant withdrawn by default
        st_d       = gport_grant_pkg::ST_RESET;
        core_gnt_d = 1'b0;
        dgnt_d     = 1'b0;
        b2b_d      = b2b_q;
        // quiet clock: no grant, no frame, no pipe
        if (~gnt_n_q || s_frame || s_pipe) begin
            gap_d = gport_grant_pkg::CNT_RESET;
        end else if (!gap_ok) begin
            gap_d = gap_q + 2'h1;
        end else begin
            gap_d = gap_q;
        end
        unique case (state_q)
            gport_grant_pkg::S_IDLE: begin
                b2b_d = gport_grant_pkg::CNT_RESET;
                // fresh grant only after the quiet gap
                if (gap_ok && s_req) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_REQUEST;
                    state_d = gport_grant_pkg::S_GNT_REQ;
                end else if (gap_ok && i_core_req) begin
                    core_gnt_d = 1'b1;
                    state_d    = gport_grant_pkg::S_CORE;
                end
            end
            gport_grant_pkg::S_CORE: begin
                // core grant is internal; dropped as its frame starts
                if (s_frame) begin
                    state_d = gport_grant_pkg::S_PCI_ACT;
                end else if (i_core_req) begin
                    core_gnt_d = 1'b1;
                end else begin
                    state_d = gport_grant_pkg::S_IDLE;
                end
            end
            gport_grant_pkg::S_GNT_REQ: begin
                if (s_pipe) begin
                    // request started: a data slot may follow at once
                    state_d = gport_grant_pkg::S_PIPE_ACT;
                    if (i_rd_pending) begin
                        gnt_n_d = 1'b0;
                        st_d    = gport_grant_pkg::ST_READ_DATA;
                        dgnt_d  = 1'b1;
                    end else if (i_wr_pending) begin
                        gnt_n_d = 1'b0;
                        st_d    = gport_grant_pkg::ST_WRITE_DATA;
                        dgnt_d  = 1'b1;
                    end
                end else if (s_frame) begin
                    state_d = gport_grant_pkg::S_PCI_ACT;
                    b2b_d   = b2b_q + 2'h1;
                    // keep the slot for the same master unless retry or limit
                    if (s_req && !i_stop_early &&
                        (b2b_q + 2'h1) < gport_grant_pkg::B2B_MAX) begin
                        gnt_n_d = 1'b0;
                        st_d    = gport_grant_pkg::ST_REQUEST;
                    end else if (i_rd_pending) begin
                        gnt_n_d = 1'b0;
                        st_d    = gport_grant_pkg::ST_READ_DATA;
                        dgnt_d  = 1'b1;
                    end else if (i_wr_pending) begin
                        gnt_n_d = 1'b0;
                        st_d    = gport_grant_pkg::ST_WRITE_DATA;
                        dgnt_d  = 1'b1;
                    end
                end else if (!s_req) begin
                    state_d = gport_grant_pkg::S_IDLE;
                end else begin
                    // latched inputs may leave the code up a little long
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_REQUEST;
                end
            end
            gport_grant_pkg::S_PIPE_ACT: begin
                // no second request grant while the burst runs
                if (!s_pipe && s_req) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_REQUEST;
                    b2b_d   = gport_grant_pkg::CNT_RESET;
                    state_d = gport_grant_pkg::S_GNT_REQ;
                end else if (!s_pipe) begin
                    state_d = gport_grant_pkg::S_WAIT_REQ;
                end else if (!dgnt_q && i_rd_pending) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_READ_DATA;
                    dgnt_d  = 1'b1;
                end else if (!dgnt_q && i_wr_pending) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_WRITE_DATA;
                    dgnt_d  = 1'b1;
                end
            end
            gport_grant_pkg::S_WAIT_REQ: begin
                // req coming back is what frees the next grant
                if (s_req) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_REQUEST;
                    b2b_d   = gport_grant_pkg::CNT_RESET;
                    state_d = gport_grant_pkg::S_GNT_REQ;
                end else if (gap_ok) begin
                    state_d = gport_grant_pkg::S_IDLE;
                end
            end
            gport_grant_pkg::S_PCI_ACT: begin
                if (!s_frame) begin
                    // last data phase: held grant lets the master go on
                    state_d = req_held ? gport_grant_pkg::S_GNT_REQ
                                       : gport_grant_pkg::S_IDLE;
                    gnt_n_d = ~(req_held && s_req && !i_stop_early);
                    st_d    = gport_grant_pkg::ST_REQUEST;
                    if (!req_held) begin
                        b2b_d = gport_grant_pkg::CNT_RESET;
                    end
                end else if (req_held && s_req && !i_stop_early) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_REQUEST;
                end else if (!req_held && !dgnt_q && i_rd_pending) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_READ_DATA;
                    dgnt_d  = 1'b1;
                end else if (!req_held && !dgnt_q && i_wr_pending) begin
                    gnt_n_d = 1'b0;
                    st_d    = gport_grant_pkg::ST_WRITE_DATA;
                    dgnt_d  = 1'b1;
                end
            end
            default: begin
                state_d = gport_grant_pkg::S_IDLE;
            end
        endcase
    end

    // state registers, frozen while the clock enable is low
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q    <= gport_grant_pkg::S_IDLE;
            gnt_n_q    <= gport_grant_pkg::GNT_N_RESET;
            st_q       <= gport_grant_pkg::ST_RESET;
            core_gnt_q <= 1'b0;
            dgnt_q     <= 1'b0;
            gap_q      <= gport_grant_pkg::CNT_RESET;
            b2b_q      <= gport_grant_pkg::CNT_RESET;
        end else if (i_clk_en) begin
            state_q    <= state_d;
            gnt_n_q    <= gnt_n_d;
            st_q       <= st_d;
            core_gnt_q <= core_gnt_d;
            dgnt_q     <= dgnt_d;
            gap_q      <= gap_d;
            b2b_q      <= b2b_d;
        end
    end

    assign o_gnt_n             = gnt_n_q;
    assign o_grant_status_code = st_q;
    assign o_core_gnt          = core_gnt_q;
    assign o_data_grant        = dgnt_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // named steps of a pipelined burst ending with req still low
    sequence burst_ends_with_req;
        i_clk_en && state_q == gport_grant_pkg::S_PIPE_ACT && !s_pipe && s_req;
    endsequence
    sequence request_grant_out;
        !gnt_n_q && st_q == gport_grant_pkg::ST_REQUEST;
    endsequence

    chk_no_req_pipeline: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_PIPE_ACT && s_pipe)
        |=> !(!gnt_n_q && st_q == gport_grant_pkg::ST_REQUEST))
        else $error("request grant pipelined during active burst");
    chk_burst_end_grant: assert property (
        burst_ends_with_req |=> request_grant_out)
        else $error("no grant after burst ended with req asserted");
    chk_req_rearm_grant: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_WAIT_REQ && s_req)
        |=> request_grant_out ##0 (state_q == gport_grant_pkg::S_GNT_REQ))
        else $error("req reassertion did not bring a grant");
    chk_withdraw_no_req: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_GNT_REQ && !s_req && !s_frame && !s_pipe)
        |=> gnt_n_q && state_q == gport_grant_pkg::S_IDLE)
        else $error("grant kept after request dropped");
    chk_b2b_limit: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_GNT_REQ && s_frame && !s_pipe
         && b2b_q + 2'h1 >= gport_grant_pkg::B2B_MAX)
        |=> !(!gnt_n_q && st_q == gport_grant_pkg::ST_REQUEST))
        else $error("grant held into a third back-to-back transaction");
    chk_retry_drop: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_PCI_ACT && s_frame && i_stop_early)
        |=> !(!gnt_n_q && st_q == gport_grant_pkg::ST_REQUEST))
        else $error("grant held despite early retry notice");
    chk_quiet_gap: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_IDLE && !gap_ok) |=> gnt_n_q)
        else $error("fresh grant before two quiet clocks");
    chk_read_slot: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_GNT_REQ && s_pipe && i_rd_pending)
        |=> !gnt_n_q && st_q[2:1] == 2'b00 && dgnt_q)
        else $error("read data grant not issued with code 00x");
    chk_write_slot: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_GNT_REQ && s_pipe
         && !i_rd_pending && i_wr_pending)
        |=> !gnt_n_q && st_q[2:1] == 2'b01 && dgnt_q)
        else $error("write data grant not issued with code 01x");
    chk_hold_into_pci: assert property (
        (i_clk_en && state_q == gport_grant_pkg::S_PCI_ACT && s_frame
         && req_held && s_req && !i_stop_early)
        |=> request_grant_out)
        else $error("held grant lost during pci transaction");
endmodule
`default_nettype wire

// ---- gport_master_model.sv ----
// master-side model for the graphics port: drives request, frame, strobe
// assumes callers enter its tasks at falling edges; pins idle high (pull-ups)
`default_nettype none
module gport_master_model (
    // clock and grant from the arbiter
    input  wire logic       i_clk_sys,
    input  wire logic       i_gnt_n,
    input  wire logic [2:0] i_grant_status_code,
    // master pins, active low
    output var  logic       o_req_n,
    output var  logic       o_frame_n,
    output var  logic       o_pipe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins start released
    initial begin
        o_req_n   = 1'b1;
        o_frame_n = 1'b1;
        o_pipe_n  = 1'b1;
    end
    // ask for the bus; count clocks until a request grant shows
    task automatic request(output int n);
        n = 0;
        @(negedge i_clk_sys);
        o_req_n = 1'b0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (!(i_gnt_n === 1'b0 &&
                     i_grant_status_code === gport_grant_pkg::ST_REQUEST) && n < 40);
    endtask
    // give the bus back
    task automatic release_req();
        @(negedge i_clk_sys);
        o_req_n = 1'b1;
    endtask
    // start the pipelined strobe
    task automatic pipe_on();
        @(negedge i_clk_sys);
        o_pipe_n = 1'b0;
    endtask
    // last strobe clock: request high marks the final one enqueued
    task automatic pipe_last();
        @(negedge i_clk_sys);
        o_req_n = 1'b1;
    endtask
    // strobe ends; request low again only if more is wanted
    task automatic pipe_off(input bit more);
        @(negedge i_clk_sys);
        o_pipe_n = 1'b1;
        o_req_n  = !more;
    endtask
    // frames four clocks apart, leaving room for turn-around and dead clocks
    task automatic pci(input int tries, output int started);
        started = 0;
        for (int i = 0; i < tries; i++) begin
            @(negedge i_clk_sys);
            if (i_gnt_n !== 1'b0) break;
            o_frame_n = 1'b0;
            started++;
            // two data phases, so the arbiter sees frame over two clocks
            repeat (2) @(negedge i_clk_sys);
            o_frame_n = 1'b1;
            @(negedge i_clk_sys);
        end
        o_req_n = 1'b1;
        repeat (2) @(negedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the grant pipelining arbiter
// assumes uut samples pins two clocks late, answer on third; uut_reg one clock later
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // design inputs
    logic       clk;
    logic       rst;
    logic       clk_en;
    logic       core_req;
    logic       rd_pend;
    logic       wr_pend;
    logic       stop_early;
    // master pins
    wire        req_n;
    wire        frame_n;
    wire        pipe_n;
    // design outputs
    logic       gnt_n;
    logic [2:0] code;
    logic       gnt_r_n;    // grant of the registered-sampling build
    logic [2:0] code_r;     // its status code
    logic       core_gnt;
    logic       data_grant;
    // bookkeeping
    int         err_count = 0;
    int         checked   = 0;
    int         cycles    = 0;

    gport_grant_arbiter #(.REGISTERED_INPUTS(1'b0)) uut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(clk_en),
        .i_req_n(req_n), .i_frame_n(frame_n), .i_pipe_n(pipe_n),
        .i_core_req(core_req), .i_rd_pending(rd_pend), .i_wr_pending(wr_pend),
        .i_stop_early(stop_early), .o_gnt_n(gnt_n), .o_grant_status_code(code),
        .o_core_gnt(core_gnt), .o_data_grant(data_grant));

    // registered-sampling build on the same pins, only its grant and status code are judged
    gport_grant_arbiter #(.REGISTERED_INPUTS(1'b1)) uut_reg (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(clk_en),
        .i_req_n(req_n), .i_frame_n(frame_n), .i_pipe_n(pipe_n),
        .i_core_req(core_req), .i_rd_pending(rd_pend), .i_wr_pending(wr_pend),
        .i_stop_early(stop_early), .o_gnt_n(gnt_r_n), .o_grant_status_code(code_r),
        .o_core_gnt(), .o_data_grant());

    gport_master_model master (
        .i_clk_sys(clk), .i_gnt_n(gnt_n), .i_grant_status_code(code),
        .o_req_n(req_n), .o_frame_n(frame_n), .o_pipe_n(pipe_n));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard: whole run needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end
    // one compare, counted
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        $display("errors %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // clocks until the grant pin reaches a level, bounded
    task automatic wait_gnt(input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (gnt_n !== lvl && n < 40);
    endtask
    // idle outputs, held by reset and kept after release
    task automatic t_reset();
        check({4'h0, gnt_n, code}, {4'h0, gport_grant_pkg::GNT_N_RESET,
              gport_grant_pkg::ST_RESET});
        check({6'h00, core_gnt, data_grant}, 8'h00);
    endtask
    // first grant and its withdrawal when request drops
    task automatic t_grant();
        int n;
        master.request(n);
        check(8'(n), 8'h03);
        check({4'h0, gnt_r_n, code_r}, {4'h0, 1'b1, gport_grant_pkg::ST_RESET});
        master.release_req();
        check({4'h0, gnt_r_n, code_r}, {4'h0, 1'b0, gport_grant_pkg::ST_REQUEST});
        wait_gnt(1'b1, n);
        check(8'(n), 8'h03);
        repeat (6) @(negedge clk);
    endtask
    // strobe with a data slot pending, then a further request at its end
    task automatic t_pipe(input bit rd);
        int n;
        int dg;
        logic [3:0] seen;
        dg = 0;
        seen = 4'hf;
        rd_pend = rd;
        wr_pend = !rd;
        master.request(n);
        master.pipe_on();
        repeat (5) begin
            @(negedge clk);
            if (data_grant === 1'b1) begin
                dg++;
                seen = {gnt_n, code};
                rd_pend = 1'b0;
                wr_pend = 1'b0;
            end
        end
        check(8'(dg), 8'h01);
        check({4'h0, seen}, {5'h00, rd ? gport_grant_pkg::ST_READ_DATA
                                       : gport_grant_pkg::ST_WRITE_DATA});
        master.pipe_last();
        master.pipe_off(1'b1);
        wait_gnt(1'b0, n);
        check(8'(n), 8'h03);
        check({5'h00, code}, {5'h00, gport_grant_pkg::ST_REQUEST});
        master.release_req();
        repeat (6) @(negedge clk);
    endtask
    // burst of several requests: grant waits for the request to come back
    task automatic t_multi();
        int n;
        int lows;
        lows = 0;
        master.request(n);
        master.pipe_on();
        repeat (3) @(negedge clk);
        master.pipe_last();
        master.pipe_off(1'b0);
        // req stays high one clock more, so only its return can bring the grant
        @(negedge clk);
        if (gnt_n === 1'b0) lows++;
        check(8'(lows), 8'h00);
        master.request(n);
        check(8'(n), 8'h03);
        master.release_req();
        repeat (6) @(negedge clk);
    endtask
    // internal grant to the core logic follows its request by one clock
    task automatic t_core();
        core_req = 1'b1;
        @(negedge clk);
        check({7'h00, core_gnt}, 8'h01);
        core_req = 1'b0;
        // enable low freezes the grant although the request is gone
        clk_en = 1'b0;
        @(negedge clk);
        check({7'h00, core_gnt}, 8'h01);
        clk_en = 1'b1;
        @(negedge clk);
        check({7'h00, core_gnt}, 8'h00);
        repeat (6) @(negedge clk);
    endtask
    // held grant over fast back-to-back frames, cut before the third
    task automatic t_b2b();
        int n;
        int s;
        master.request(n);
        master.pci(4, s);
        check(8'(s), 8'h02);
        repeat (6) @(negedge clk);
    endtask
    // retry notice removes the held grant so no repeat frame starts
    task automatic t_retry();
        int n;
        int s;
        master.request(n);
        fork
            master.pci(4, s);
            begin
                @(negedge frame_n);
                @(negedge clk);
                stop_early = 1'b1;
            end
        join
        stop_early = 1'b0;
        check(8'(s), 8'h01);
        repeat (6) @(negedge clk);
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        core_req = 1'b0;
        rd_pend = 1'b0;
        wr_pend = 1'b0;
        stop_early = 1'b0;
        repeat (2) @(negedge clk);
        t_reset();
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_grant();
        t_pipe(1'b1);
        t_pipe(1'b0);
        t_multi();
        t_core();
        t_b2b();
        t_retry();
        close_out();
    end
endmodule
`default_nettype wire
